/* File: tb/ccdlt_partner.sv */
`timescale 1ns/1ps
// Host side: serial register writer and sync pin source
module ccdlt_partner (
  input  wire logic i_clk_sys,
  output logic      o_ser_load,
  output logic      o_ser_clk,
  output logic      o_ser_data,
  output logic      o_ext_sync
);
  logic pol_ff;

  // Idle levels at time zero
  initial begin
    pol_ff     = 1'b0;
    o_ser_load = 1'b1;
    o_ser_clk  = 1'b0;
    o_ser_data = 1'b1;
    o_ext_sync = 1'b1;
  end

  // Word MSB first, three clocks per half bit, clock parked low
  task automatic write_reg(input logic [7:0] addr, input logic [23:0] data);
    logic [31:0] word;
    word = {addr, data};
    @(posedge i_clk_sys) #1 o_ser_load = 1'b0;
    for (int b = 31; b >= 0; b--) begin
      @(posedge i_clk_sys) #1;
      o_ser_clk  = 1'b0;
      o_ser_data = word[b];
      repeat (3) @(posedge i_clk_sys);
      #1 o_ser_clk = 1'b1;
      repeat (2) @(posedge i_clk_sys);
    end
    @(posedge i_clk_sys) #1;
    o_ser_clk  = 1'b0;
    o_ser_data = ~word[0];
    repeat (3) @(posedge i_clk_sys);
    #1 o_ser_load = 1'b1;
    repeat (6) @(posedge i_clk_sys);
  endtask : write_reg

  // idle pin sits at the inactive level
  task automatic set_pol(input logic p);
    pol_ff = p;
    @(posedge i_clk_sys) #1 o_ext_sync = ~p;
  endtask : set_pol

  // four-clock pulse at the active level
  task automatic sync_pulse();
    @(posedge i_clk_sys) #1 o_ext_sync = pol_ff;
    repeat (4) @(posedge i_clk_sys);
    #1 o_ext_sync = ~pol_ff;
  endtask : sync_pulse
endmodule : ccdlt_partner

/* File: tb/tb_ccdlt_timing.sv */
`timescale 1ns/1ps
module tb_ccdlt_timing
  import ccdlt_pkg::*;
;
  logic        clk, rst, ser_load, ser_clk, ser_data, ext_sync;
  logic [11:0] pix_in, pix_out;
  logic        rg, ha, hb, refc, datc, dph, stb, lsync, fsync;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          rise_t [4] = '{6, 16, 26, 36};
  int          fall_t [4] = '{26, 36, 6, 16};
  // Rows: rg fall, hclk rise, ref edge, data edge, out phase
  logic [5:0]  cfg [4][5] = '{'{6'h05, 6'h00, 6'h3b, 6'h10, 6'h2a},
                             '{6'h3b, 6'h1f, 6'h00, 6'h2b, 6'h0b},
                             '{6'h10, 6'h3b, 6'h21, 6'h00, 6'h3b},
                             '{6'h2f, 6'h2b, 6'h15, 6'h3f, 6'h00}};

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ccdlt_timing i_ccdlt_timing (.i_clk_sys(clk), .i_rst(rst), .i_ser_load(ser_load), .i_ser_clk(ser_clk),
    .i_ser_data(ser_data), .i_ext_sync(ext_sync), .i_pixel_data(pix_in), .o_reset_gate_clock(rg),
    .o_hclk_phase_a(ha), .o_hclk_phase_b(hb), .o_reference_sample_clock(refc), .o_data_sample_clock(datc),
    .o_data_phase(dph), .o_data_strobe(stb), .o_pixel_data(pix_out), .o_line_sync(lsync),
    .o_frame_sync(fsync));

  ccdlt_partner i_ccdlt_partner (.i_clk_sys(clk), .o_ser_load(ser_load), .o_ser_clk(ser_clk),
    .o_ser_data(ser_data), .o_ext_sync(ext_sync));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  // quadrant times twelve plus saturated offset
  function automatic int pos(input logic [5:0] c);
    return c[5:4] * 12 + ((c[3:0] > 11) ? 11 : c[3:0]);
  endfunction : pos

  function automatic logic inwin(input int k, input int s, input int len);
    return ((k - s + 48) % 48) < len;
  endfunction : inwin

  // Cycles until line (sel 0) or frame (sel 1) sync reaches lvl
  task automatic edge_gap(input bit sel, input bit lvl, output int n);
    logic prev, cur;
    prev = sel ? fsync : lsync;
    for (n = 1; n < 2000; n++) begin
      @(posedge clk) #2;
      cur = sel ? fsync : lsync;
      if (cur === lvl && prev !== lvl) break;
      prev = cur;
    end
  endtask : edge_gap

  task automatic pix_win(input int r);
    logic [5:0] c [5];
    int         p [5];
    logic       prev;
    c = cfg[r];
    for (int i = 0; i < 5; i++) p[i] = pos(c[i]);
    #1 pix_in = 12'h0a0 + 12'(r);
    i_ccdlt_partner.write_reg(OFS_SAMPLE, {4'h0, 2'(r), c[4], c[3], c[2]});
    i_ccdlt_partner.write_reg(OFS_HSCLK, {12'h000, c[1], c[0]});
    // Let a full pixel period pass under the new settings, sample off the edge
    repeat (60) @(posedge clk);
    #2;
    prev = 1'b1;
    for (int n = 0; n < 200 && !(rg === 1'b1 && prev === 1'b0); n++) begin
      prev = rg;
      @(posedge clk) #2;
    end
    for (int k = 0; k < 48; k++) begin
      chk(rg, k < p[0]);
      chk(ha, inwin(k, p[1], 24));
      chk(hb, !inwin(k, p[1], 24));
      chk(refc, k == p[2]);
      chk(datc, k == p[3]);
      chk(dph, inwin(k, p[4], 24));
      chk(stb, inwin(k, rise_t[r], (fall_t[r] - rise_t[r] + 48) % 48));
      @(posedge clk) #2;
    end
    chk(pix_out, 12'h0a0 + 12'(r));
    $display("test pixel window %0d done", r);
  endtask : pix_win

  task automatic line_test();
    int n;
    i_ccdlt_partner.write_reg(OFS_LINE_LEN, {2'h0, 10'h3ff, 12'h002});
    i_ccdlt_partner.write_reg(OFS_FRAME_LEN, {1'h0, 11'd2, 12'h001});
    edge_gap(1, 0, n);
    edge_gap(1, 0, n);
    chk(12'(n), 12'd1056);
    edge_gap(1, 1, n);
    chk(12'(n), 12'd384);
    // Frame sync rises at the start of line 1, so the next gap is line 1
    edge_gap(0, 0, n);
    chk(12'(n), 12'd384);
    edge_gap(0, 0, n);
    chk(12'(n), 12'd288);
    edge_gap(0, 0, n);
    chk(12'(n), 12'd384);
    $display("test line and frame done");
  endtask : line_test

  // Pulse in mid-frame, then look for a realigned frame start
  task automatic sync_try(input bit exp);
    int n;
    edge_gap(1, 0, n);
    repeat (450) @(posedge clk);
    i_ccdlt_partner.sync_pulse();
    repeat (4) @(posedge clk);
    #2 chk(fsync, !exp);
    $display("test sync pulse done");
  endtask : sync_try

  // Main sequence
  initial begin
    rst    = 1'b1;
    pix_in = 12'h000;
    repeat (3) @(posedge clk);
    #2 chk({rg, ha, hb, lsync, fsync}, 12'h007);
    @(posedge clk) #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    for (int r = 0; r < 4; r++) pix_win(r);
    line_test();
    i_ccdlt_partner.write_reg(OFS_SYNC_COUNT, 24'h1);
    sync_try(0);
    i_ccdlt_partner.write_reg(OFS_ROLE, 24'h0);
    sync_try(1);
    sync_try(1);
    i_ccdlt_partner.write_reg(OFS_SYNC_COUNT, 24'h0);
    sync_try(0);
    i_ccdlt_partner.write_reg(OFS_SYNC_COUNT, 24'h3);
    sync_try(0);
    sync_try(0);
    sync_try(1);
    i_ccdlt_partner.write_reg(OFS_SYNC_COUNT, 24'hf);
    sync_try(1);
    sync_try(0);
    i_ccdlt_partner.write_reg(OFS_SYNC_COUNT, 24'h1);
    i_ccdlt_partner.write_reg(OFS_POLARITY, 24'h1);
    i_ccdlt_partner.set_pol(1'b1);
    sync_try(1);
    final_report();
  end

  // Watchdog, about three times the expected run of 18k cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    final_report();
  end
endmodule : tb_ccdlt_timing

/* File: verilog/ccdlt_pkg.sv */
package ccdlt_pkg;
  // Edge grid of one pixel period
  localparam int unsigned PIX_STEPS      = 48;
  localparam int unsigned HALF_STEPS     = 24;
  localparam int unsigned QUAD_STEPS     = 12;
  localparam logic [5:0]  RG_RISE_POS    = 6'h00;
  localparam int unsigned LINE_SETUP_PIX = 4;
  // Serial write word: address in the top byte, data below
  localparam int unsigned SER_BITS       = 32;
  localparam int unsigned SER_ADDR_LSB   = 24;
  // Register offsets
  localparam logic [7:0] OFS_POLARITY   = 8'h01;
  localparam logic [7:0] OFS_SAMPLE     = 8'h02;
  localparam logic [7:0] OFS_HSCLK      = 8'h03;
  localparam logic [7:0] OFS_SYNC_COUNT = 8'h0a;
  localparam logic [7:0] OFS_ROLE       = 8'hd6;
  localparam logic [7:0] OFS_LINE_LEN   = 8'h10;
  localparam logic [7:0] OFS_RISE_POS   = 8'h11;
  localparam logic [7:0] OFS_FRAME_LEN  = 8'h12;
  // Field positions (LSB) inside the data word
  localparam int unsigned F_POL        = 0;
  localparam int unsigned F_REF_EDGE   = 0;
  localparam int unsigned F_DAT_EDGE   = 6;
  localparam int unsigned F_OUT_PHASE  = 12;
  localparam int unsigned F_STB_PHASE  = 18;
  localparam int unsigned F_RG_FALL    = 0;
  localparam int unsigned F_HCLK_RISE  = 6;
  localparam int unsigned F_SYNC_CNT   = 0;
  localparam int unsigned F_ROLE       = 0;
  localparam int unsigned F_LINE_GRAY  = 0;
  localparam int unsigned F_AUX_LEN    = 12;
  localparam int unsigned F_LINE_RISE  = 0;
  localparam int unsigned F_FRAME_RISE = 10;
  localparam int unsigned F_LAST_LEN   = 0;
  localparam int unsigned F_FRAME_TOT  = 12;
  // Sync count special codes
  localparam logic [3:0] SYNC_OFF  = 4'h0;
  localparam logic [3:0] SYNC_ALL  = 4'h1;
  localparam logic [3:0] SYNC_ONCE = 4'hf;

  // Software visible configuration
  typedef struct packed {
    logic        pol;
    logic [5:0]  ref_edge;
    logic [5:0]  dat_edge;
    logic [5:0]  out_phase;
    logic [1:0]  stb_phase;
    logic [5:0]  rg_fall;
    logic [5:0]  hclk_rise;
    logic [3:0]  sync_cnt;
    logic        role;
    logic [11:0] line_gray;
    logic [9:0]  aux_len;
    logic [9:0]  line_rise;
    logic [3:0]  frame_rise;
    logic [11:0] last_len;
    logic [10:0] frame_tot;
  } ccdlt_cfg_t;

  localparam ccdlt_cfg_t CFG_RESET = '{
    pol: 1'b0, ref_edge: 6'h20, dat_edge: 6'h00, out_phase: 6'h00, stb_phase: 2'h0,
    rg_fall: 6'h10, hclk_rise: 6'h00, sync_cnt: 4'h0, role: 1'b1,
    line_gray: 12'h000, aux_len: 10'h3ff, line_rise: 10'h000, frame_rise: 4'h1,
    last_len: 12'h000, frame_tot: 11'h000};
endpackage : ccdlt_pkg

/* File: verilog/ccdlt_timing.sv */
`timescale 1ns/1ps
// How it works
// - Reset gate clock falls at the programmed 6-bit edge position.
// - Reset gate clock always rises at edge position zero.
// - First horizontal clock rises where programmed, falls 24 steps later.
// - Second horizontal clock is always the inverse of the first.
// - Edge code: top two bits pick quadrant, low bits position 0 to 11.
// - Reference and data sample clocks sit at their own 6-bit positions.
// - Data outputs switch at output phase, fall 24 steps later.
// - Data strobe rise and fall picked from a four-entry table.
// - Every programmable edge except the strobe edges reaches any of the 48 positions; the reset gate fall reaches all but zero, where the rise wins.
// - Powers up with role bit one, sync input ignored; role bit zero enables external sync input.
// - Sync input polarity bit, active low after reset.
// - Sync count zero ignores the external sync input.
// - Sync count one realigns the frame on every pulse.
// - Sync count 2 to 14 realigns after the Nth pulse.
// - Sync count 15 realigns once after the first pulse only.
// - Line sync goes low when each line starts.
// - Frame sync goes low when each frame starts.
// - Lines per frame counted by 11 bits against the programmed total.
// - Line sync rises when the 10-bit aux counter hits its position.
// - Final line of each frame uses its own 12-bit length.
// - Pixel period divided into 48 equal steps.
module ccdlt_timing
  import ccdlt_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_ser_load,
  input  wire logic        i_ser_clk,
  input  wire logic        i_ser_data,
  input  wire logic        i_ext_sync,
  input  wire logic [11:0] i_pixel_data,
  output logic             o_reset_gate_clock,
  output logic             o_hclk_phase_a,
  output logic             o_hclk_phase_b,
  output logic             o_reference_sample_clock,
  output logic             o_data_sample_clock,
  output logic             o_data_phase,
  output logic             o_data_strobe,
  output logic [11:0]      o_pixel_data,
  output logic             o_line_sync,
  output logic             o_frame_sync
);

  typedef struct packed {
    ccdlt_cfg_t  cfg;
    logic [2:0]  ld_sync;
    logic [2:0]  ck_sync;
    logic [1:0]  sd_sync;
    logic [2:0]  es_sync;
    logic [31:0] shreg;
    logic [5:0]  phase;
    logic [2:0]  setup;
    logic [11:0] pix;
    logic [9:0]  aux;
    logic [10:0] line;
    logic [3:0]  spulse;
    logic        sdone;
    logic        rg;
    logic        ha;
    logic        hb;
    logic        refc;
    logic        datc;
    logic        dph;
    logic        stb;
    logic [11:0] pixd;
    logic        hd;
    logic        vd;
  } ccdlt_state_t;

  ccdlt_state_t s_ff;
  ccdlt_state_t nxt_s;

  // quadrant decode, low field saturates at the quadrant end
  function automatic logic [5:0] ccdlt_pos(input logic [5:0] code);
    logic [5:0] low;
    low = (code[3:0] > 4'd11) ? 6'd11 : {2'b00, code[3:0]};
    return 6'(code[5:4] * QUAD_STEPS) + low;
  endfunction : ccdlt_pos

  // Position half a pixel period later, wrapped
  function automatic logic [5:0] ccdlt_half(input logic [5:0] p);
    return (p >= 6'(HALF_STEPS)) ? 6'(p - 6'(HALF_STEPS)) : 6'(p + 6'(HALF_STEPS));
  endfunction : ccdlt_half

  function automatic logic [11:0] ccdlt_gray(input logic [11:0] b);
    return b ^ {1'b0, b[11:1]};
  endfunction : ccdlt_gray

  logic [5:0]  pos_rg;
  logic [5:0]  pos_hr;
  logic [5:0]  pos_hf;
  logic [5:0]  pos_ref;
  logic [5:0]  pos_dat;
  logic [5:0]  pos_or;
  logic [5:0]  pos_of;
  logic [5:0]  pos_sr;
  logic [5:0]  pos_sf;
  logic        pix_end;
  logic        sync_act;
  logic        sync_edge;
  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [23:0] wr_data;
  logic        resync;
  logic [11:0] len_sel;
  logic        line_end;
  logic        frame_end;

  assign pos_rg  = ccdlt_pos(s_ff.cfg.rg_fall);
  assign pos_hr  = ccdlt_pos(s_ff.cfg.hclk_rise);
  assign pos_hf  = ccdlt_half(pos_hr);
  assign pos_ref = ccdlt_pos(s_ff.cfg.ref_edge);
  assign pos_dat = ccdlt_pos(s_ff.cfg.dat_edge);
  assign pos_or  = ccdlt_pos(s_ff.cfg.out_phase);
  assign pos_of  = ccdlt_half(pos_or);

  always_comb begin
    unique case (s_ff.cfg.stb_phase)
      2'h0: begin pos_sr = 6'd6;  pos_sf = 6'd26; end
      2'h1: begin pos_sr = 6'd16; pos_sf = 6'd36; end
      2'h2: begin pos_sr = 6'd26; pos_sf = 6'd6;  end
      2'h3: begin pos_sr = 6'd36; pos_sf = 6'd16; end
    endcase
  end

  // one step per clock, 48 steps per pixel
  assign pix_end = (s_ff.phase == 6'(PIX_STEPS - 1));

  // Serial write lands on the rising edge of the load line
  assign wr_stb  = s_ff.ld_sync[1] & ~s_ff.ld_sync[2];
  assign wr_addr = s_ff.shreg[SER_BITS-1:SER_ADDR_LSB];
  assign wr_data = s_ff.shreg[SER_ADDR_LSB-1:0];

  assign sync_act  = s_ff.cfg.pol ? s_ff.es_sync[1] : ~s_ff.es_sync[1];
  assign sync_edge = ~s_ff.cfg.role & sync_act
                   & ~(s_ff.cfg.pol ? s_ff.es_sync[2] : ~s_ff.es_sync[2]);

  always_comb begin
    resync = 1'b0;
    if (sync_edge) begin
      if (s_ff.cfg.sync_cnt == SYNC_ALL) begin
        resync = 1'b1;
      end else if (s_ff.cfg.sync_cnt == SYNC_ONCE) begin
        resync = ~s_ff.sdone;
      end else if (s_ff.cfg.sync_cnt != SYNC_OFF) begin
        resync = (4'(s_ff.spulse + 4'd1) == s_ff.cfg.sync_cnt);
      end
    end
  end

  // last line length, Gray compare after setup
  assign len_sel   = (s_ff.line == s_ff.cfg.frame_tot) ? s_ff.cfg.last_len : s_ff.cfg.line_gray;
  assign line_end  = pix_end && (s_ff.setup == 3'(LINE_SETUP_PIX)) && (ccdlt_gray(s_ff.pix) == len_sel);
  assign frame_end = line_end && (s_ff.line == s_ff.cfg.frame_tot);

  // Next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ld_sync = {s_ff.ld_sync[1:0], i_ser_load};
    nxt_s.ck_sync = {s_ff.ck_sync[1:0], i_ser_clk};
    nxt_s.sd_sync = {s_ff.sd_sync[0], i_ser_data};
    nxt_s.es_sync = {s_ff.es_sync[1:0], i_ext_sync};
    // Shift MSB first on serial clock rise while load is low
    if (s_ff.ck_sync[1] & ~s_ff.ck_sync[2] & ~s_ff.ld_sync[1]) begin
      nxt_s.shreg = {s_ff.shreg[SER_BITS-2:0], s_ff.sd_sync[1]};
    end
    // Register writes
    if (wr_stb) begin
      unique case (wr_addr)
        OFS_POLARITY: nxt_s.cfg.pol = wr_data[F_POL];
        OFS_SAMPLE: begin
          nxt_s.cfg.ref_edge  = wr_data[F_REF_EDGE +: 6];
          nxt_s.cfg.dat_edge  = wr_data[F_DAT_EDGE +: 6];
          nxt_s.cfg.out_phase = wr_data[F_OUT_PHASE +: 6];
          nxt_s.cfg.stb_phase = wr_data[F_STB_PHASE +: 2];
        end
        OFS_HSCLK: begin
          nxt_s.cfg.rg_fall   = wr_data[F_RG_FALL +: 6];
          nxt_s.cfg.hclk_rise = wr_data[F_HCLK_RISE +: 6];
        end
        OFS_SYNC_COUNT: nxt_s.cfg.sync_cnt = wr_data[F_SYNC_CNT +: 4];
        OFS_ROLE: nxt_s.cfg.role = wr_data[F_ROLE];
        OFS_LINE_LEN: begin
          nxt_s.cfg.line_gray = wr_data[F_LINE_GRAY +: 12];
          nxt_s.cfg.aux_len   = wr_data[F_AUX_LEN +: 10];
        end
        OFS_RISE_POS: begin
          nxt_s.cfg.line_rise  = wr_data[F_LINE_RISE +: 10];
          nxt_s.cfg.frame_rise = wr_data[F_FRAME_RISE +: 4];
        end
        OFS_FRAME_LEN: begin
          nxt_s.cfg.last_len  = wr_data[F_LAST_LEN +: 12];
          nxt_s.cfg.frame_tot = wr_data[F_FRAME_TOT +: 11];
        end
        default: ;
      endcase
    end
    // Step counter within the pixel
    nxt_s.phase = pix_end ? 6'h00 : 6'(s_ff.phase + 6'd1);
    // fall then rise, rise wins on a tie
    if (s_ff.phase == pos_rg) begin
      nxt_s.rg = 1'b0;
    end
    if (s_ff.phase == RG_RISE_POS) begin
      nxt_s.rg = 1'b1;
    end
    if (s_ff.phase == pos_hr) begin
      nxt_s.ha = 1'b1;
    end else if (s_ff.phase == pos_hf) begin
      nxt_s.ha = 1'b0;
    end
    nxt_s.hb = ~nxt_s.ha;
    nxt_s.refc = (s_ff.phase == pos_ref);
    nxt_s.datc = (s_ff.phase == pos_dat);
    if (s_ff.phase == pos_or) begin
      nxt_s.dph  = 1'b1;
      nxt_s.pixd = i_pixel_data;
    end else if (s_ff.phase == pos_of) begin
      nxt_s.dph = 1'b0;
    end
    if (s_ff.phase == pos_sr) begin
      nxt_s.stb = 1'b1;
    end else if (s_ff.phase == pos_sf) begin
      nxt_s.stb = 1'b0;
    end
    // line and frame counting at pixel boundaries
    if (pix_end) begin
      if (line_end) begin
        nxt_s.setup = 3'h0;
        nxt_s.pix   = 12'h000;
        nxt_s.aux   = 10'h000;
        nxt_s.line  = frame_end ? 11'h000 : 11'(s_ff.line + 11'd1);
        nxt_s.hd = 1'b0;
        if (frame_end) begin
          nxt_s.vd = 1'b0;
        end else if (11'(s_ff.line + 11'd1) == {7'h00, s_ff.cfg.frame_rise}) begin
          nxt_s.vd = 1'b1;
        end
      end else begin
        if (s_ff.setup != 3'(LINE_SETUP_PIX)) begin
          nxt_s.setup = 3'(s_ff.setup + 3'd1);
        end else begin
          nxt_s.pix = 12'(s_ff.pix + 12'd1);
        end
        nxt_s.aux = (s_ff.aux == s_ff.cfg.aux_len) ? 10'h000 : 10'(s_ff.aux + 10'd1);
        if (s_ff.aux == s_ff.cfg.line_rise) begin
          nxt_s.hd = 1'b1;
        end
      end
    end
    if (sync_edge) begin
      nxt_s.spulse = resync ? 4'h0 : 4'(s_ff.spulse + 4'd1);
      if (s_ff.cfg.sync_cnt == SYNC_ONCE) begin
        nxt_s.sdone = 1'b1;
      end
    end
    if (wr_stb && wr_addr == OFS_SYNC_COUNT) begin
      nxt_s.spulse = 4'h0;
      nxt_s.sdone  = 1'b0;
    end
    if (resync) begin
      nxt_s.phase = 6'h00;
      nxt_s.setup = 3'h0;
      nxt_s.pix   = 12'h000;
      nxt_s.aux   = 10'h000;
      nxt_s.line  = 11'h000;
      nxt_s.hd    = 1'b0;
      nxt_s.vd    = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      // Edge-detected synchronisers start at the idle pin level, so no false edge follows reset
      s_ff <= '{cfg: CFG_RESET, ld_sync: 3'b111, es_sync: 3'b111, hb: 1'b1, hd: 1'b1, vd: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state flops
  assign o_reset_gate_clock       = s_ff.rg;
  assign o_hclk_phase_a           = s_ff.ha;
  assign o_hclk_phase_b           = s_ff.hb;
  assign o_reference_sample_clock = s_ff.refc;
  assign o_data_sample_clock      = s_ff.datc;
  assign o_data_phase             = s_ff.dph;
  assign o_data_strobe            = s_ff.stb;
  assign o_pixel_data             = s_ff.pixd;
  assign o_line_sync              = s_ff.hd;
  assign o_frame_sync             = s_ff.vd;

  // Writes and realignment disturb the fixed timing relations
  logic disturb;
  assign disturb = wr_stb | resync;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst || disturb);

  sequence s_half_high(sig);
    sig [*8] ##16 sig ##1 !sig;
  endsequence

  a_rg_rise_zero: assert property (s_ff.phase == RG_RISE_POS |=> s_ff.rg)
    else $error("reset gate did not rise at step zero");
  a_rg_fall_pos: assert property ((s_ff.phase == pos_rg) && (pos_rg != RG_RISE_POS) |=> !s_ff.rg)
    else $error("reset gate did not fall at its position");
  a_hclk_half: assert property ($rose(s_ff.ha) |-> s_half_high(s_ff.ha))
    else $error("horizontal clock high time not 24 steps");
  a_hclk_inverse: assert property (s_ff.hb == !s_ff.ha)
    else $error("second horizontal clock not inverse");
  a_hclk_period: assert property ($rose(s_ff.ha) |-> ##48 $rose(s_ff.ha))
    else $error("horizontal clock period not 48 steps");
  a_dphase_half: assert property ($rose(s_ff.dph) |-> s_half_high(s_ff.dph))
    else $error("data phase high time not 24 steps");
  a_strobe_code: assert property ((s_ff.cfg.stb_phase == 2'h1) && (s_ff.phase == 6'd16) |=>
                                  s_ff.stb ##20 !s_ff.stb)
    else $error("strobe edges wrong for phase code one");
  a_ref_sample: assert property ($rose(s_ff.refc) |-> $past(s_ff.phase) == pos_ref)
    else $error("reference sample at wrong step");
  // Realignment itself must not disable these two
  a_sync_off: assert property (disable iff (i_rst) (s_ff.cfg.sync_cnt == SYNC_OFF || s_ff.cfg.role) |-> !resync)
    else $error("realignment while sync disabled");
  a_sync_once: assert property (disable iff (i_rst) s_ff.sdone && s_ff.cfg.sync_cnt == SYNC_ONCE |-> !resync)
    else $error("repeated realignment in single-shot mode");
  a_line_low: assert property (line_end |=> !s_ff.hd && s_ff.pix == 12'h000 && s_ff.setup == 3'h0)
    else $error("line sync not low at line start");
  a_frame_low: assert property (frame_end |=> !s_ff.vd && s_ff.line == 11'h000)
    else $error("frame sync not low at frame start");

endmodule : ccdlt_timing
